// ==== ppi_fifo.sv ====
`timescale 1ns/10ps
module ppi_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input logic clk,
  input logic rst_n,
  ppi_stream_if.rx push,
  ppi_stream_if.tx pop
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign push.ready = !full;
  assign pop.valid = !empty;
  assign pop.data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push.valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= push.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (push.valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (pop.ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ==== ppi_pkg.sv ====
package ppi_pkg;

  // memory geometry
  localparam int FLASH_AW = 11;
  localparam int EE_AW = 8;
  localparam int FIFO_DEPTH = 16;

  // load strobe action codes {action_bit1, action_bit0}
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // command bytes
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;

  // fuse byte layout, zero means programmed
  localparam int FUSE_SERIAL_BIT = 5;
  localparam int FUSE_BOD_LEVEL_BIT = 4;
  localparam int FUSE_BOD_EN_BIT = 3;
  localparam int FUSE_CKSEL_MSB = 2;
  localparam int FUSE_CKSEL_LSB = 0;
  localparam logic [5:0] FUSE_RESET = 6'h1a;
  localparam logic [1:0] FUSE_RSVD = 2'h3;

  // lock byte layout
  localparam int LOCK_ONE_BIT = 1;
  localparam int LOCK_TWO_BIT = 2;
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic [4:0] LOCK_RSVD_HI = 5'h1f;

  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] BLOCKED_BYTE = 8'h00;

  // identification bytes, values arbitrary
  localparam logic [7:0] SIG_BYTE0 = 8'h5a;
  localparam logic [7:0] SIG_BYTE1 = 8'h3c;
  localparam logic [7:0] SIG_BYTE2 = 8'h81;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_NS = 700000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int ENTRY_HOLD_NS = 100;
  localparam int ENTRY_HOLD_CYCLES = (ENTRY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {md_off, md_settle, md_active, md_failed} ppi_mode_t;

  typedef struct packed {
    logic to_ee;
    logic hi;
    logic [FLASH_AW-1:0] addr;
    logic [7:0] data;
  } ppi_wreq_t;

endpackage

// ==== ppi_prog_port.sv ====
// Contract
// - lock one programmed, lock two not: flash and eeprom writes refused
// - both locks programmed: writes refused and memory verify reads blocked
// - only chip erase returns lock bits to unprogrammed; reset also reloads LOCK_RESET here
// - fuse writes refused once any lock bit is programmed
// - serial download fuse enables serial programming at zero, defaults zero
// - brown-out enable at zero; enable and level fuses default one
// - clock select fuses default to binary 010
// - three signature bytes at addresses zero to two, parallel and serial
// - mode 3 serial signature reads return zero, one and two
// - load strobe: 00 address, 01 data, 10 command, 11 nothing
// - byte select zero picks low byte, one picks high byte
// - ready/busy low while programming, high when ready
// - data bus driven by device only while output enable is low
// - commands: erase 80, write fuses 40, write locks 20
// - commands: write flash 10, write eeprom 11
// - commands: signature 08, fuse/lock 04, flash 02, eeprom 03
// - erase clears memories then locks, keeps fuses, no ready/busy activity
// - write strobe after data load starts programming and lowers ready/busy
// - command and address kept across many locations
// - flash read drives low byte on select zero, high byte on one
// - fuse byte: bit5 serial, bit4 level, bit3 enable, bits 2..0 clock
`timescale 1ns/10ps
module ppi_prog_port #(
  parameter int PROG_CYCLES = ppi_pkg::PROG_CYCLES,
  parameter int FLASH_AW = ppi_pkg::FLASH_AW,
  parameter int EE_AW = ppi_pkg::EE_AW,
  parameter int FIFO_DEPTH = ppi_pkg::FIFO_DEPTH,
  parameter logic [7:0] SIG0 = ppi_pkg::SIG_BYTE0,
  parameter logic [7:0] SIG1 = ppi_pkg::SIG_BYTE1,
  parameter logic [7:0] SIG2 = ppi_pkg::SIG_BYTE2
) (
  input logic clk,
  input logic rst_n,
  input logic prog_level,
  input logic load_strobe_clock,
  input logic load_action_bit0,
  input logic load_action_bit1,
  input logic byte_select,
  input logic wr_n,
  input logic oe_n,
  input logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic ready_busy_n,
  output logic prog_mode_active,
  input logic [1:0] ser_sig_addr,
  output logic [7:0] ser_sig_data,
  output logic serial_prog_enable,
  output logic brownout_detect_enable,
  output logic brownout_level_fuse,
  output logic [2:0] clock_select_fuses
);
  import ppi_pkg::*;

  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam int SW = 15;
  localparam int HW = $clog2(ENTRY_HOLD_CYCLES + 1);
  localparam int FLASH_DEPTH = 1 << FLASH_AW;
  localparam int EE_DEPTH = 1 << EE_AW;
  localparam int REQ_W = $bits(ppi_wreq_t);

  // pin synchronisation
  logic [SW-1:0] pin_raw;
  logic [SW-1:0] pin_sync;
  logic strobe_s;
  logic [1:0] action_s;
  logic bs_s;
  logic wr_n_s;
  logic oe_n_s;
  logic prog_s;
  logic [7:0] data_s;

  assign pin_raw = {load_strobe_clock, load_action_bit1, load_action_bit0, byte_select,
                    wr_n, oe_n, prog_level, data_in};

  // write strobe and output enable idle high so reset leaves no false falling edge
  ppi_sync #(
    .W(SW),
    .RST_VAL(15'h0600)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(pin_raw),
    .q(pin_sync)
  );

  assign {strobe_s, action_s, bs_s, wr_n_s, oe_n_s, prog_s, data_s} = pin_sync;

  logic strobe_prev;
  logic wr_prev;
  logic strobe_rise;
  logic wr_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strobe_prev <= 1'b0;
      wr_prev <= 1'b1;
    end else begin
      strobe_prev <= strobe_s;
      wr_prev <= wr_n_s;
    end
  end

  assign strobe_rise = strobe_s && !strobe_prev;
  assign wr_fall = !wr_n_s && wr_prev;

  // entry into programming mode
  ppi_mode_t mode;
  logic [HW-1:0] hold_cnt;
  logic active;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode <= md_off;
      hold_cnt <= '0;
    end else begin
      case (mode)
        md_off: begin
          hold_cnt <= '0;
          if (prog_s) begin
            mode <= bs_s ? md_failed : md_settle;
          end
        end
        md_settle: begin
          hold_cnt <= hold_cnt + 1'b1;
          if (!prog_s) begin
            mode <= md_off;
          end else if (bs_s) begin
            // select moved too soon after the high level; stay out until level drops
            mode <= md_failed;
          end else if (hold_cnt == HW'(ENTRY_HOLD_CYCLES - 1)) begin
            mode <= md_active;
          end
        end
        md_active: begin
          if (!prog_s) begin
            mode <= md_off;
          end
        end
        default: begin
          if (!prog_s) begin
            mode <= md_off;
          end
        end
      endcase
    end
  end

  assign active = (mode == md_active);
  assign prog_mode_active = active;

  // loaded command, address and data, held until reloaded
  logic [7:0] cmd;
  logic [7:0] addr_lo;
  logic [7:0] addr_hi;
  logic [7:0] data_lo;
  logic [7:0] data_hi;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd <= 8'h00;
      addr_lo <= 8'h00;
      addr_hi <= 8'h00;
      data_lo <= 8'hff;
      data_hi <= 8'hff;
    end else if (active && strobe_rise) begin
      case (action_s)
        ACT_ADDR: begin
          if (bs_s) begin
            addr_hi <= data_s;
          end else begin
            addr_lo <= data_s;
          end
        end
        ACT_DATA: begin
          if (bs_s) begin
            data_hi <= data_s;
          end else begin
            data_lo <= data_s;
          end
        end
        ACT_CMD: begin
          cmd <= data_s;
        end
        default: begin
        end
      endcase
    end
  end

  logic [FLASH_AW-1:0] flash_addr;
  logic [EE_AW-1:0] ee_addr;

  // address survives programming so one command covers a run of locations
  assign flash_addr = FLASH_AW'({addr_hi, addr_lo});
  assign ee_addr = EE_AW'(addr_lo);

  // lock bits and protection modes
  logic [1:0] lock_bits;
  logic lock_bit_one;
  logic lock_bit_two;
  logic write_locked;
  logic verify_locked;
  logic erase_run;
  logic erase_done;

  assign lock_bit_one = lock_bits[0];
  assign lock_bit_two = lock_bits[1];
  assign write_locked = !lock_bit_one;
  assign verify_locked = !lock_bit_one && !lock_bit_two;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_bits <= LOCK_RESET;
    end else if (erase_done) begin
      lock_bits <= LOCK_RESET;
    end else if (active && wr_fall && cmd == CMD_WR_LOCK) begin
      // lock bits only move toward programmed here
      lock_bits <= lock_bits & {data_lo[LOCK_TWO_BIT], data_lo[LOCK_ONE_BIT]};
    end
  end

  // fuses, unaffected by erase
  logic [5:0] fuses;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fuses <= FUSE_RESET;
    end else if (active && wr_fall && cmd == CMD_WR_FUSE && lock_bits == LOCK_RESET) begin
      fuses <= data_lo[5:0];
    end
  end

  // serial side sees decoded enables plus the raw level and clock select fuses, never the fuse write path
  assign serial_prog_enable = !fuses[FUSE_SERIAL_BIT];
  assign brownout_detect_enable = !fuses[FUSE_BOD_EN_BIT];
  assign brownout_level_fuse = fuses[FUSE_BOD_LEVEL_BIT];
  assign clock_select_fuses = fuses[FUSE_CKSEL_MSB:FUSE_CKSEL_LSB];

  // chip erase sweep, runs in the background with no ready/busy change
  logic [FLASH_AW-1:0] erase_ptr;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erase_run <= 1'b0;
      erase_ptr <= '0;
    end else if (erase_run) begin
      erase_ptr <= erase_ptr + 1'b1;
      if (erase_ptr == FLASH_AW'(FLASH_DEPTH - 1)) begin
        erase_run <= 1'b0;
      end
    end else if (active && wr_fall && cmd == CMD_CHIP_ERASE) begin
      erase_run <= 1'b1;
      erase_ptr <= '0;
    end
  end

  // locks clear on the same edge that blanks the last location of both arrays
  assign erase_done = erase_run && (erase_ptr == FLASH_AW'(FLASH_DEPTH - 1));

  // write requests queue ahead of the programming timer
  ppi_stream_if #(.W(REQ_W)) req_in ();
  ppi_stream_if #(.W(REQ_W)) req_out ();
  ppi_wreq_t new_req;
  logic is_mem_write;

  assign is_mem_write = (cmd == CMD_WR_FLASH) || (cmd == CMD_WR_EE);
  assign new_req.to_ee = (cmd == CMD_WR_EE);
  assign new_req.hi = bs_s;
  assign new_req.addr = (cmd == CMD_WR_EE) ? FLASH_AW'(ee_addr) : flash_addr;
  // eeprom bytes always come from the low data register, whatever select says
  assign new_req.data = (bs_s && cmd != CMD_WR_EE) ? data_hi : data_lo;
  assign req_in.data = new_req;
  // a strobe arriving while the queue is full is dropped; ready/busy is already low
  assign req_in.valid = active && wr_fall && is_mem_write && !write_locked;

  ppi_fifo #(
    .W(REQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .push(req_in.rx),
    .pop(req_out.tx)
  );

  // programming engine
  logic eng_busy;
  logic [CW-1:0] eng_cnt;
  ppi_wreq_t eng_req;
  logic eng_done;

  // erase owns the arrays, so queued writes wait for it
  assign req_out.ready = !eng_busy && !erase_run;
  assign eng_done = eng_busy && (eng_cnt == CW'(PROG_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      eng_busy <= 1'b0;
      eng_cnt <= '0;
      eng_req <= '0;
    end else if (eng_busy) begin
      eng_cnt <= eng_cnt + 1'b1;
      if (eng_done) begin
        eng_busy <= 1'b0;
      end
    end else if (req_out.valid && req_out.ready) begin
      eng_busy <= 1'b1;
      eng_cnt <= '0;
      eng_req <= req_out.data;
    end
  end

  assign ready_busy_n = !(eng_busy || req_out.valid);

  // memory arrays, contents are not cleared by reset
  logic [7:0] flash_lo [FLASH_DEPTH];
  logic [7:0] flash_hi [FLASH_DEPTH];
  logic [7:0] ee_mem [EE_DEPTH];

  always_ff @(posedge clk) begin
    if (erase_run) begin
      flash_lo[erase_ptr] <= ERASED_BYTE;
      flash_hi[erase_ptr] <= ERASED_BYTE;
      ee_mem[erase_ptr[EE_AW-1:0]] <= ERASED_BYTE;
    end else if (eng_done) begin
      if (eng_req.to_ee) begin
        ee_mem[eng_req.addr[EE_AW-1:0]] <= eng_req.data;
      end else if (eng_req.hi) begin
        flash_hi[eng_req.addr] <= eng_req.data;
      end else begin
        flash_lo[eng_req.addr] <= eng_req.data;
      end
    end
  end

  // read path
  function automatic logic [7:0] sig_byte(input logic [1:0] idx);
    if (idx == 2'h0) begin
      sig_byte = SIG0;
    end else if (idx == 2'h1) begin
      sig_byte = SIG1;
    end else if (idx == 2'h2) begin
      sig_byte = SIG2;
    end else begin
      sig_byte = 8'h00;
    end
  endfunction

  logic [7:0] next_data_out;

  always_comb begin
    next_data_out = 8'h00;
    case (cmd)
      CMD_RD_FLASH: begin
        if (verify_locked) begin
          next_data_out = BLOCKED_BYTE;
        end else begin
          next_data_out = bs_s ? flash_hi[flash_addr] : flash_lo[flash_addr];
        end
      end
      CMD_RD_EE: begin
        next_data_out = verify_locked ? BLOCKED_BYTE : ee_mem[ee_addr];
      end
      CMD_RD_SIG: begin
        next_data_out = sig_byte(addr_lo[1:0]);
      end
      CMD_RD_FUSE: begin
        if (bs_s) begin
          next_data_out = {LOCK_RSVD_HI, lock_bit_two, lock_bit_one, 1'b1};
        end else begin
          next_data_out = {FUSE_RSVD, fuses};
        end
      end
      default: begin
        next_data_out = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_out <= 8'h00;
      data_oe <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe <= active && !oe_n_s;
    end
  end

  // serial signature port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ser_sig_data <= 8'h00;
    end else if (verify_locked) begin
      ser_sig_data <= {6'h00, ser_sig_addr};
    end else begin
      ser_sig_data <= sig_byte(ser_sig_addr);
    end
  end

endmodule

// ==== ppi_prog_port_asserts.sv ====
`timescale 1ns/10ps
module ppi_prog_port_asserts #(
  parameter int PROG_CYCLES = 20,
  parameter logic [7:0] SIG0 = 8'h00,
  parameter logic [7:0] SIG1 = 8'h00,
  parameter logic [7:0] SIG2 = 8'h00
) (
  input logic clk,
  input logic rst_n,
  input logic prog_level,
  input logic byte_select,
  input logic wr_n,
  input logic oe_n,
  input logic data_oe,
  input logic ready_busy_n,
  input logic prog_mode_active,
  input logic [1:0] ser_sig_addr,
  input logic [7:0] ser_sig_data,
  input logic serial_prog_enable,
  input logic brownout_detect_enable,
  input logic brownout_level_fuse,
  input logic [2:0] clock_select_fuses
);
  int since_wr;
  int low_run;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // saturates so a long idle never wraps into a false recent strobe
  always_ff @(posedge clk) begin
    if (!rst_n) since_wr <= 100;
    else if (!wr_n) since_wr <= 0;
    else if (since_wr < 100) since_wr <= since_wr + 1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || ready_busy_n) low_run <= 0;
    else low_run <= low_run + 1;
  end
  function automatic logic [7:0] sig_of(input logic [1:0] a);
    case (a)
      2'h0: sig_of = SIG0;
      2'h1: sig_of = SIG1;
      2'h2: sig_of = SIG2;
      default: sig_of = 8'h00;
    endcase
  endfunction
  reset_dflt_a: assert property (disable iff (1'b0) !rst_n |=> ready_busy_n && !prog_mode_active && !data_oe
    && serial_prog_enable && !brownout_detect_enable && brownout_level_fuse && clock_select_fuses == 3'h2)
    else $error("reset defaults wrong");
  oe_rise_a: assert property ($rose(data_oe) |-> !$past(oe_n, 1) && !$past(oe_n, 2))
    else $error("bus driven without output enable");
  oe_drop_a: assert property (oe_n [*4] |=> !data_oe)
    else $error("bus still driven after output enable released");
  idle_quiet_a: assert property (!prog_mode_active [*2] |-> !data_oe)
    else $error("bus driven outside programming mode");
  sig_serial_a: assert property ($past(rst_n) |-> ser_sig_data == sig_of($past(ser_sig_addr))
    || ser_sig_data == {6'h0, $past(ser_sig_addr)})
    else $error("serial signature byte wrong");
  busy_cause_a: assert property ($fell(ready_busy_n) |-> since_wr < 8)
    else $error("busy without a write strobe");
  busy_len_a: assert property ($rose(ready_busy_n) |-> low_run >= PROG_CYCLES)
    else $error("busy period too short");
  mode_entry_a: assert property ($rose(prog_mode_active) |-> $past(prog_level, 10) && !$past(byte_select, 5))
    else $error("mode entered without settled level");
  mode_level_a: assert property (prog_mode_active |-> $past(prog_level, 3))
    else $error("mode active without programming level");
  fuse_cause_a: assert property ($changed({serial_prog_enable, brownout_detect_enable, brownout_level_fuse,
    clock_select_fuses}) |-> since_wr < 8)
    else $error("fuse outputs changed without a write strobe");
endmodule

bind ppi_prog_port ppi_prog_port_asserts #(.PROG_CYCLES(PROG_CYCLES), .SIG0(SIG0), .SIG1(SIG1), .SIG2(SIG2))
  ppi_prog_port_asserts_inst (.clk(clk), .rst_n(rst_n), .prog_level(prog_level), .byte_select(byte_select),
  .wr_n(wr_n), .oe_n(oe_n), .data_oe(data_oe), .ready_busy_n(ready_busy_n), .prog_mode_active(prog_mode_active),
  .ser_sig_addr(ser_sig_addr), .ser_sig_data(ser_sig_data), .serial_prog_enable(serial_prog_enable),
  .brownout_detect_enable(brownout_detect_enable), .brownout_level_fuse(brownout_level_fuse),
  .clock_select_fuses(clock_select_fuses));

// ==== ppi_prog_port_tb_top.sv ====
`timescale 1ns/10ps
module ppi_prog_port_tb_top;
  import ppi_pkg::*;
  localparam int PC = 800;
  typedef struct packed {logic [1:0] sel; logic [7:0] v;} ppi_note_t;
  logic clk, rst_n, prog_level, load_strobe_clock, load_action_bit0, load_action_bit1, byte_select, wr_n, oe_n;
  logic data_oe, ready_busy_n, prog_mode_active, serial_prog_enable, brownout_detect_enable, brownout_level_fuse;
  logic rb_hist;
  logic [7:0] data_in, data_out, dq, ser_sig_data, got, hv, ev;
  logic [1:0] ser_sig_addr;
  logic [2:0] clock_select_fuses;
  logic [31:0] seed = 32'h91c5;
  logic [7:0] wd [18];
  ppi_note_t q [$];
  ppi_note_t e;
  int errors = 0;
  int n_tests = 0;
  event smp;
  assign data_in = data_oe ? data_out : dq;
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ppi_prog_port #(.PROG_CYCLES(PC)) ppi_prog_port_inst (.clk(clk), .rst_n(rst_n), .prog_level(prog_level),
    .load_strobe_clock(load_strobe_clock), .load_action_bit0(load_action_bit0), .load_action_bit1(load_action_bit1),
    .byte_select(byte_select), .wr_n(wr_n), .oe_n(oe_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .ready_busy_n(ready_busy_n), .prog_mode_active(prog_mode_active), .ser_sig_addr(ser_sig_addr),
    .ser_sig_data(ser_sig_data), .serial_prog_enable(serial_prog_enable),
    .brownout_detect_enable(brownout_detect_enable), .brownout_level_fuse(brownout_level_fuse),
    .clock_select_fuses(clock_select_fuses));
  ppi_programmer ppi_programmer_inst (.clk(clk), .prog_level(prog_level), .load_strobe_clock(load_strobe_clock),
    .load_action_bit0(load_action_bit0), .load_action_bit1(load_action_bit1), .byte_select(byte_select),
    .wr_n(wr_n), .oe_n(oe_n), .dq(dq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] sigv(input int i);
    return (i == 0) ? SIG_BYTE0 : (i == 1) ? SIG_BYTE1 : (i == 2) ? SIG_BYTE2 : 8'h00;
  endfunction
  task automatic wrap_up;
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic note(input logic [1:0] sel, input logic [7:0] v);
    q.push_back({sel, v});
    -> smp;
    #1;
  endtask
  // monitor: oldest note against what the outputs show now
  always @(smp) begin
    e = q.pop_front();
    case (e.sel)
      2'h0: got = data_oe ? data_out : 8'hxx;
      2'h1: got = {6'h0, prog_mode_active, rb_hist};
      2'h2: got = ser_sig_data;
      default: got = {2'h0, serial_prog_enable, brownout_detect_enable, brownout_level_fuse, clock_select_fuses};
    endcase
    n_tests++;
    if (got !== e.v) begin
      errors++;
      $display("[ERR] %0t exp %h got %h", $time, e.v, got);
    end
  end
  always @(posedge clk) rb_hist <= rb_hist & ready_busy_n;
  task automatic cmd(input logic [7:0] c);
    ppi_programmer_inst.load(ACT_CMD, 1'b0, c);
  endtask
  task automatic adr(input logic bs, input logic [7:0] v);
    ppi_programmer_inst.load(ACT_ADDR, bs, v);
  endtask
  task automatic dat(input logic bs, input logic [7:0] v);
    ppi_programmer_inst.load(ACT_DATA, bs, v);
  endtask
  task automatic wr(input logic bs);
    ppi_programmer_inst.strobe_wr(bs);
  endtask
  task automatic rd(input logic bs, input logic [7:0] v);
    ppi_programmer_inst.read(bs);
    note(2'h0, v);
    ppi_programmer_inst.release_bus();
  endtask
  // bounded wait, then the ready level itself is what gets compared
  task automatic wait_rdy;
    for (int k = 0; k < 20 * PC && ready_busy_n !== 1'b1; k++) @(negedge clk);
    rb_hist = ready_busy_n;
    note(2'h1, 8'h03);
  endtask
  task automatic erase;
    cmd(CMD_CHIP_ERASE);
    rb_hist = 1'b1;
    wr(1'b0);
    repeat (2100) @(negedge clk);
    note(2'h1, 8'h03);
  endtask
  task automatic ser_chk(input logic m3);
    for (int i = 0; i < 3; i++) begin
      ser_sig_addr = i[1:0];
      repeat (2) @(negedge clk);
      note(2'h2, m3 ? 8'(i) : sigv(i));
    end
  endtask
  initial begin
    rst_n = 1'b0;
    ser_sig_addr = 2'h0;
    rb_hist = 1'b1;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    note(2'h3, 8'h2a);
    @(negedge clk);
    note(2'h1, 8'h01);
    ppi_programmer_inst.enter(1'b1);
    note(2'h1, 8'h01);
    ppi_programmer_inst.enter(1'b0);
    note(2'h1, 8'h03);
    erase();
    cmd(CMD_WR_FLASH);
    adr(1'b1, 8'h00);
    rb_hist = 1'b1;
    for (int i = 0; i < 18; i++) begin
      seed = lfsr(seed);
      wd[i] = seed[7:0];
      adr(1'b0, 8'(i));
      dat(1'b0, wd[i]);
      wr(1'b0);
    end
    note(2'h1, 8'h02);
    wait_rdy();
    seed = lfsr(seed);
    hv = seed[15:8];
    adr(1'b0, 8'h00);
    dat(1'b1, hv);
    wr(1'b1);
    wait_rdy();
    cmd(CMD_RD_FLASH);
    for (int i = 0; i < 18; i++) begin
      adr(1'b0, 8'(i));
      rd(1'b0, (i == 17) ? ERASED_BYTE : wd[i]);
    end
    adr(1'b0, 8'h00);
    rd(1'b1, hv);
    rd(1'b0, wd[0]);
    cmd(CMD_WR_EE);
    adr(1'b0, 8'hc3);
    seed = lfsr(seed);
    ev = seed[7:0];
    dat(1'b0, ev);
    wr(1'b1);
    wait_rdy();
    cmd(CMD_RD_EE);
    rd(1'b0, ev);
    ppi_programmer_inst.load(ACT_IDLE, 1'b0, ~ev);
    rd(1'b0, ev);
    cmd(CMD_RD_SIG);
    for (int i = 0; i < 4; i++) begin
      adr(1'b0, 8'(i));
      rd(1'b0, sigv(i));
    end
    ser_chk(1'b0);
    cmd(CMD_WR_FUSE);
    dat(1'b0, 8'he5);
    wr(1'b0);
    note(2'h3, 8'h15);
    cmd(CMD_RD_FUSE);
    rd(1'b0, 8'he5);
    rd(1'b1, 8'hff);
    cmd(CMD_WR_LOCK);
    dat(1'b0, 8'hfd);
    wr(1'b0);
    cmd(CMD_WR_FUSE);
    dat(1'b0, 8'hff);
    wr(1'b0);
    note(2'h3, 8'h15);
    cmd(CMD_WR_FLASH);
    adr(1'b0, 8'h01);
    dat(1'b0, ~wd[1]);
    rb_hist = 1'b1;
    wr(1'b0);
    repeat (10) @(negedge clk);
    note(2'h1, 8'h03);
    cmd(CMD_RD_FLASH);
    rd(1'b0, wd[1]);
    cmd(CMD_WR_LOCK);
    dat(1'b0, 8'hfb);
    wr(1'b0);
    cmd(CMD_RD_FLASH);
    rd(1'b0, BLOCKED_BYTE);
    cmd(CMD_RD_SIG);
    adr(1'b0, 8'h00);
    rd(1'b0, SIG_BYTE0);
    ser_chk(1'b1);
    cmd(CMD_WR_LOCK);
    dat(1'b0, 8'hff);
    wr(1'b0);
    cmd(CMD_RD_FUSE);
    rd(1'b1, 8'hf9);
    erase();
    cmd(CMD_RD_FUSE);
    rd(1'b1, 8'hff);
    rd(1'b0, 8'he5);
    cmd(CMD_RD_FLASH);
    adr(1'b0, 8'h01);
    rd(1'b0, ERASED_BYTE);
    wrap_up();
  end
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    wrap_up();
  end
endmodule

// ==== ppi_programmer.sv ====
`timescale 1ns/10ps
module ppi_programmer (
  input logic clk,
  output logic prog_level,
  output logic load_strobe_clock,
  output logic load_action_bit0,
  output logic load_action_bit1,
  output logic byte_select,
  output logic wr_n,
  output logic oe_n,
  output logic [7:0] dq
);
  logic [7:0] dq_q = 8'hff;
  int pace = 3;
  // bus under output enable shows the inverse, never a stale copy that could pass for a read
  assign dq = oe_n ? dq_q : ~dq_q;
  initial begin
    {prog_level, load_strobe_clock, load_action_bit1, load_action_bit0, byte_select} = 5'h0;
    {wr_n, oe_n} = 2'h3;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic enter(input logic bs);
    prog_level = 1'b0;
    byte_select = bs;
    idle(10);
    prog_level = 1'b1;
    idle(20);
  endtask
  task automatic load(input logic [1:0] act, input logic bs, input logic [7:0] v);
    {load_action_bit1, load_action_bit0} = act;
    byte_select = bs;
    dq_q = v;
    idle(pace);
    load_strobe_clock = 1'b1;
    idle(pace);
    load_strobe_clock = 1'b0;
    idle(pace);
  endtask
  task automatic strobe_wr(input logic bs);
    byte_select = bs;
    idle(pace);
    wr_n = 1'b0;
    idle(pace + 1);
    wr_n = 1'b1;
    idle(pace);
  endtask
  task automatic read(input logic bs);
    byte_select = bs;
    oe_n = 1'b0;
    idle(6);
  endtask
  task automatic release_bus;
    oe_n = 1'b1;
    idle(pace + 3);
  endtask
endmodule

// ==== ppi_stream_if.sv ====
`timescale 1ns/10ps
interface ppi_stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

// ==== ppi_sync.sv ====
`timescale 1ns/10ps
module ppi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input logic clk,
  input logic rst_n,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // meta feeds q only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
